// ---- logic/diag_consts.svh ----
// constants of the counter diagnostic and test unit
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH
`define NUM_PORTS 12
`define PORT_CC_A 16'hac00
`define PORT_CC_B 16'hac02
`define PORT_GG_A 16'h9900
`define PORT_GG_B 16'h9902
`define PORT_FC_A 16'h9840
`define PORT_FC_B 16'h9842
`define PORT_PC_A 16'h9820
`define PORT_PC_B 16'h9822
`define PORT_B2_A 16'h9880
`define PORT_B2_B 16'h9882
`define PORT_FP_A 16'h9808
`define PORT_FP_B 16'h980a
`define PORT_DIR_BIT 16'h0001
`define SWITCH_ADDR 16'h9c04
`define SIG_CTRL_ADDR 16'h9c10
`define TEST_SEL_ADDR 16'h9c11
`define STATUS_ADDR 16'h9c12
`define RAM_TOP 16'h0800
`define CHECK_CYCLES 16'h0100
`define STEP_LOW 8'hff
`define SIG_LAST 6'h21
`define SIG_RAM_PAT 16'h5a3c
`define SIG_PROM_HI 8'ha5
`define SIG_KEY_HI 8'h3c
`define ERR_PROM0 8'h31
`define ERR_PROM1 8'h32
`define ERR_PROM2 8'h33
`define ERR_PROM3 8'h36
`define VCO_LO_MHZ 400
`define VCO_HI_MHZ 500
`define VCO_STEP_KHZ 50
`define DAC_TOP_MHZ 27000
`define DAC_STEP_MHZ 2
`define T_NONE 8'h00
`define T_SELF 8'h01
`define T_LAMP 8'h02
`define T_SEG 8'h03
`define T_DIG 8'h04
`define T_KEY 8'h05
`define T_RAMP 8'h06
`define T_VCO 8'h07
`define T_ALTER 8'h10
`define KEY_EXIT 5'h10
`endif

// ---- logic/diag_pkg.sv ----
// types of the counter diagnostic and test unit
`include "diag_consts.svh"
package diag_pkg;
  typedef enum logic [1:0] {
    PWR_CHECK = 2'b00,
    PWR_RUN = 2'b01,
    PWR_PROM_FAIL = 2'b11,
    PWR_RAM_FAIL = 2'b10
  } pwr_t;
  typedef enum logic [1:0] {
    DISP_DASH = 2'b00,
    DISP_NORMAL = 2'b01,
    DISP_E = 2'b10,
    DISP_NUM = 2'b11
  } disp_t;
  typedef struct packed {
    pwr_t pwr;
    logic [15:0] chk;
    logic [7:0] err;
    logic [7:0] test;
    logic [`NUM_PORTS-1:0][7:0] out;
    logic [`NUM_PORTS-1:0][7:0] oe_n;
    logic [`NUM_PORTS-1:0][7:0] pin1;
    logic [`NUM_PORTS-1:0][7:0] pin2;
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [7:0] rdata;
    logic [1:0] frc;
    logic [2:0] hwt;
    logic ph;
    logic [15:0] walk;
    logic sg_busy;
    logic [5:0] sg_cnt;
    logic [15:0] sg_pat;
    logic sa_start;
    logic sa_stop;
    logic sa_clock;
    logic sa_probe;
    logic [15:0] div;
    logic tick;
    logic [3:0] idx;
    logic [7:0] seg;
    logic [7:0] dig;
    logic [7:0] ann;
    logic [13:0] vco;
    logic [13:0] dac;
    logic div2;
    logic gate;
    logic [15:0] ent_addr;
    logic [2:0] ent_n;
    logic [7:0] ent_dat;
    logic rd_pend;
    logic [15:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    disp_t disp;
    logic [15:0] dval;
  } state_t;
endpackage

// ---- logic/counter_diagnostic_test_unit.sv ----
// diagnostic, self test and signature stimulus logic of the counter
// Behaviour
// [RULE1] analyzer compresses each window's samples into a four-character signature
// [RULE2] analyzer samples probe on each clock strobe between start and stop
// [RULE3] forced instruction mode walks every address of the whole range
// [RULE4] firmware drives start and stop itself in software signature mode
// [RULE5] power-on checks run with dashes shown on every digit
// [RULE6] all checks pass gives normal mode; RAM failure shows all E
// [RULE7] program memory failure shows code 31, 32, 33 or 36 plus signature
// [RULE8] memory failure signatures only come from the power-up sequence
// [RULE9] keys map to hex 0 to F; clear screen key leaves the test
// [RULE10] keyboard test shows key row and column and a per-key signature
// [RULE11] a brief high on the hardware test input starts the keyboard test
// [RULE12] test 01 sets oscillator to 400 MHz, halves it, counts the result
// [RULE13] test 02 lights every segment, annunciator and decimal point
// [RULE14] test 03 steps one segment per digit plus one annunciator
// [RULE15] test 04 steps one whole digit, then annunciators, at sample rate
// [RULE16] test 06 ramps filter DAC from zero to 27 GHz in 2 MHz steps
// [RULE17] test 07 sweeps 400 to 500 MHz in 50 kHz, bands two, three only
// [RULE18] test 10 reads after four hex digits, writes two more to RAM or I/O; code writes only RAM below 0800 and port output latches
// [RULE19] port read gives output latch for outputs, pin level for inputs
// [RULE20] controller writes halved filter value high to 9842, low to 9840
// [RULE21] controller writes oscillator value high to 9822, low to 9820
// [RULE22] start, stop and clock strobes are clean pulses on the bus clock
`include "diag_consts.svh"
module counter_diagnostic_test_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  output logic [7:0] cpu_rdata,
  input wire logic [`NUM_PORTS-1:0][7:0] port_pin_in,
  output logic [`NUM_PORTS-1:0][7:0] port_pin_out,
  output logic [`NUM_PORTS-1:0][7:0] port_pin_oe_n,
  input wire logic [7:0] addr_switch_in,
  input wire logic forced_clear_instruction,
  input wire logic hw_key_test,
  input wire logic ram_ok,
  input wire logic [3:0] prom_ok,
  input wire logic key_valid,
  input wire logic [4:0] key_code,
  input wire logic [7:0] sample_rate,
  input wire logic [1:0] band,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic [15:0] walk_addr,
  output logic sa_start,
  output logic sa_stop,
  output logic sa_clock,
  output logic sa_probe,
  output diag_pkg::disp_t disp_mode,
  output logic [15:0] disp_value,
  output logic [7:0] seg_on,
  output logic [7:0] digit_on,
  output logic [7:0] ann_on,
  output logic [13:0] vco_prog,
  output logic [13:0] dac_prog,
  output logic div2_en,
  output logic gate_run
);
  import diag_pkg::*;

  localparam logic [13:0] VCO_LO = 14'(`VCO_LO_MHZ * 1000 / `VCO_STEP_KHZ);
  localparam logic [13:0] VCO_HI = 14'(`VCO_HI_MHZ * 1000 / `VCO_STEP_KHZ);
  localparam logic [13:0] DAC_TOP = 14'(`DAC_TOP_MHZ / `DAC_STEP_MHZ);

  state_t q;
  state_t d;
  logic [`NUM_PORTS-1:0][7:0] view;
  logic [5:0] pd;
  logic [5:0] td;
  logic [5:0] wd;
  logic wen;
  logic [15:0] wa;
  logic [7:0] wdat;
  logic [3:0] hx;

  // {hit, direction, index}; direction sits on the odd byte above each port
  function automatic logic [5:0] port_dec(input logic [15:0] a);
    logic [15:0] b;
    b = a & ~`PORT_DIR_BIT;
    case (b)
      `PORT_CC_A: port_dec = {1'b1, a[0], 4'h0};
      `PORT_CC_B: port_dec = {1'b1, a[0], 4'h1};
      `PORT_GG_A: port_dec = {1'b1, a[0], 4'h2};
      `PORT_GG_B: port_dec = {1'b1, a[0], 4'h3};
      `PORT_FC_A: port_dec = {1'b1, a[0], 4'h4};
      `PORT_FC_B: port_dec = {1'b1, a[0], 4'h5};
      `PORT_PC_A: port_dec = {1'b1, a[0], 4'h6};
      `PORT_PC_B: port_dec = {1'b1, a[0], 4'h7};
      `PORT_B2_A: port_dec = {1'b1, a[0], 4'h8};
      `PORT_B2_B: port_dec = {1'b1, a[0], 4'h9};
      `PORT_FP_A: port_dec = {1'b1, a[0], 4'ha};
      `PORT_FP_B: port_dec = {1'b1, a[0], 4'hb};
      default: port_dec = 6'h00;
    endcase
  endfunction

  function automatic logic [3:0] key_hex(input logic [4:0] k);
    key_hex = k[3:0];
  endfunction

  function automatic logic [7:0] key_coord(input logic [4:0] k);
    case (k)
      5'h00: key_coord = 8'h12;
      5'h01: key_coord = 8'h21;
      5'h02: key_coord = 8'h22;
      5'h03: key_coord = 8'h23;
      5'h04: key_coord = 8'h31;
      5'h05: key_coord = 8'h32;
      5'h06: key_coord = 8'h33;
      5'h07: key_coord = 8'h41;
      5'h08: key_coord = 8'h42;
      5'h09: key_coord = 8'h43;
      5'h0a: key_coord = 8'h44;
      5'h0b: key_coord = 8'h34;
      5'h0c: key_coord = 8'h24;
      5'h0d: key_coord = 8'h13;
      5'h0e: key_coord = 8'h11;
      5'h0f: key_coord = 8'h47;
      default: key_coord = 8'h00;
    endcase
  endfunction

  // lowest failing device is reported when several fail
  function automatic logic [7:0] prom_code(input logic [3:0] p);
    if (!p[0]) prom_code = `ERR_PROM0;
    else if (!p[1]) prom_code = `ERR_PROM1;
    else if (!p[2]) prom_code = `ERR_PROM2;
    else prom_code = `ERR_PROM3;
  endfunction

  for (genvar i = 0; i < `NUM_PORTS; i++) begin : g_view
    assign view[i] = (q.out[i] & ~q.oe_n[i]) | (q.pin2[i] & q.oe_n[i]);
  end

  always_comb begin
    d = q;
    pd = port_dec(cpu_addr);
    td = port_dec(q.ent_addr);
    hx = key_hex(key_code);
    wen = cpu_wr;
    wa = cpu_addr;
    wdat = cpu_wdata;
    d.pin1 = port_pin_in;
    d.pin2 = q.pin1;
    d.sw1 = addr_switch_in;
    d.sw2 = q.sw1;
    d.frc = {q.frc[0], forced_clear_instruction};
    d.hwt = {q.hwt[1:0], hw_key_test};
    d.sa_start = 1'b0;
    d.sa_stop = 1'b0;
    d.sa_clock = 1'b0;
    d.mem_rd = 1'b0;
    d.mem_wr = 1'b0;
    d.rd_pend = 1'b0;
    d.tick = 1'b0;
    d.seg = 8'h00;
    d.dig = 8'h00;
    d.ann = 8'h00;
    d.div2 = 1'b0;
    d.gate = 1'b0;
    if (q.div == 16'h0000) begin
      d.div = {sample_rate, `STEP_LOW};
      d.tick = 1'b1;
    end else begin
      d.div = q.div - 16'h0001;
    end
    if (cpu_wr && cpu_addr == `SIG_CTRL_ADDR) begin
      d.sa_start = cpu_wdata[0]; // RULE4
      d.sa_stop = cpu_wdata[1]; // RULE4
      d.sa_probe = cpu_wdata[2];
      d.sa_clock = cpu_wdata[3] & ~q.sa_clock; // RULE22
    end
    case (q.pwr)
      PWR_CHECK: begin
        d.disp = DISP_DASH; // RULE5
        if (q.chk != `CHECK_CYCLES) begin
          d.chk = q.chk + 16'h0001;
        end else if (!ram_ok) begin
          d.pwr = PWR_RAM_FAIL; // RULE6
          d.disp = DISP_E; // RULE6
          d.sg_busy = 1'b1;
          d.sg_cnt = 6'h00;
          d.sg_pat = `SIG_RAM_PAT;
        end else if (prom_ok != 4'hf) begin
          d.pwr = PWR_PROM_FAIL; // RULE7
          d.err = prom_code(prom_ok);
          d.disp = DISP_NUM;
          d.dval = {8'h00, prom_code(prom_ok)}; // RULE7
          d.sg_busy = 1'b1; // RULE8
          d.sg_cnt = 6'h00;
          d.sg_pat = {`SIG_PROM_HI, prom_code(prom_ok)};
        end else begin
          d.pwr = PWR_RUN; // RULE6
          d.disp = DISP_NORMAL;
        end
      end
      default: begin
        // failure states hold until power is cycled
      end
    endcase
    if (q.pwr == PWR_RUN) begin
      if (cpu_wr && cpu_addr == `TEST_SEL_ADDR) begin
        d.test = cpu_wdata;
        d.idx = 4'h0;
        d.ent_n = 3'h0;
        d.vco = VCO_LO;
        d.dac = 14'h0000;
        d.disp = DISP_NORMAL;
      end else begin
        case (q.test)
          `T_SELF: begin
            d.vco = VCO_LO; // RULE12
            d.div2 = 1'b1; // RULE12
            d.gate = 1'b1; // RULE12
          end
          `T_LAMP: begin
            d.seg = 8'hff; // RULE13
            d.dig = 8'hff;
            d.ann = 8'hff;
          end
          `T_SEG: begin
            d.seg = 8'h01 << q.idx[2:0]; // RULE14
            d.dig = 8'hff;
            d.ann = 8'h01 << q.idx[2:0];
            if (q.tick) d.idx = {1'b0, q.idx[2:0] + 3'h1};
          end
          `T_DIG: begin
            if (!q.idx[3]) begin
              d.dig = 8'h01 << q.idx[2:0]; // RULE15
              d.seg = 8'hff;
            end else begin
              d.ann = 8'h01 << q.idx[2:0];
            end
            if (q.tick) d.idx = q.idx + 4'h1;
          end
          `T_KEY: begin
            if (key_valid && key_code != `KEY_EXIT) begin
              d.disp = DISP_NUM;
              d.dval = {8'h00, key_coord(key_code)}; // RULE10
              if (!q.sg_busy) begin
                d.sg_busy = 1'b1; // RULE10
                d.sg_cnt = 6'h00;
                d.sg_pat = {`SIG_KEY_HI, key_coord(key_code)};
              end
            end
          end
          `T_RAMP: begin
            if (q.tick) begin
              d.sa_clock = 1'b1;
              if (q.dac == DAC_TOP) begin
                d.dac = 14'h0000; // RULE16
                d.sa_start = 1'b1;
                d.sa_stop = 1'b1;
              end else begin
                d.dac = q.dac + 14'h0001; // RULE16
              end
            end
          end
          `T_VCO: begin
            if (q.tick && band[1]) begin
              d.vco = (q.vco >= VCO_HI) ? VCO_LO : q.vco + 14'h0001; // RULE17
            end
          end
          `T_ALTER: begin
            if (key_valid && !key_code[4]) begin
              if (q.ent_n < 3'h4) begin
                d.ent_addr = {q.ent_addr[11:0], hx}; // RULE18
                d.ent_n = q.ent_n + 3'h1;
                if (q.ent_n == 3'h3) begin
                  d.mem_addr = {q.ent_addr[11:0], hx}; // RULE18
                  d.mem_rd = 1'b1;
                  d.rd_pend = 1'b1;
                end
              end else if (q.ent_n == 3'h4) begin
                d.ent_dat = {4'h0, hx};
                d.ent_n = 3'h5;
              end else begin
                d.ent_n = 3'h4;
                d.ent_dat = {q.ent_dat[3:0], hx};
                // a bus write in the same cycle wins over the alter write
                if (td[5] && !td[4] && !cpu_wr) begin
                  wen = 1'b1; // RULE18
                  wa = q.ent_addr;
                  wdat = {q.ent_dat[3:0], hx};
                  d.dval = {8'h00, q.ent_dat[3:0], hx};
                end else if (!td[5] && q.ent_addr < `RAM_TOP) begin
                  d.mem_wr = 1'b1; // RULE18
                  d.mem_addr = q.ent_addr;
                  d.mem_wdata = {q.ent_dat[3:0], hx};
                  d.dval = {8'h00, q.ent_dat[3:0], hx};
                end
              end
            end
          end
          default: begin
          end
        endcase
      end
      if (q.rd_pend) begin
        d.disp = DISP_NUM;
        if (td[5]) d.dval = {8'h00, td[4] ? ~q.oe_n[td[3:0]] : view[td[3:0]]};
        else d.dval = {8'h00, mem_rdata};
      end
      if (key_valid && key_code == `KEY_EXIT) begin
        d.test = `T_NONE; // RULE9
        d.disp = DISP_NORMAL;
      end
      if (q.hwt[1] && !q.hwt[2]) begin
        d.test = `T_KEY; // RULE11
        d.disp = DISP_NUM;
        d.dval = 16'h0000;
      end
    end
    wd = port_dec(wa);
    if (wen && wd[5]) begin
      if (wd[4]) d.oe_n[wd[3:0]] = ~wdat;
      else d.out[wd[3:0]] = wdat;
    end
    if (q.sg_busy) begin
      d.sg_cnt = q.sg_cnt + 6'h01;
      if (q.sg_cnt == 6'h00) begin
        d.sa_start = 1'b1; // RULE22
      end else if (q.sg_cnt == `SIG_LAST) begin
        d.sa_stop = 1'b1; // RULE22
        d.sg_busy = 1'b0;
      end else if (q.sg_cnt[0]) begin
        d.sa_probe = q.sg_pat[q.sg_cnt[4:1]];
      end else begin
        d.sa_clock = 1'b1;
      end
    end
    // strobe only every second cycle so the clock has clean edges
    if (q.frc[1]) begin
      d.ph = ~q.ph;
      d.sa_clock = q.ph; // RULE3
      if (q.ph) begin
        d.walk = q.walk + 16'h0001; // RULE3
        if (q.walk == 16'hffff) begin
          d.sa_start = 1'b1;
          d.sa_stop = 1'b1;
        end
      end
    end
    if (cpu_rd) begin
      if (pd[5]) begin
        d.rdata = pd[4] ? ~q.oe_n[pd[3:0]] : view[pd[3:0]]; // RULE19
      end else begin
        case (cpu_addr)
          `SWITCH_ADDR: d.rdata = q.sw2;
          `SIG_CTRL_ADDR: d.rdata = {5'h00, q.sa_probe, q.sg_busy, q.frc[1]};
          `TEST_SEL_ADDR: d.rdata = q.test;
          `STATUS_ADDR: d.rdata = {6'h00, q.pwr};
          default: d.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.oe_n <= '1;
    end else begin
      q <= d;
    end
  end

  assign cpu_rdata = q.rdata;
  assign port_pin_out = q.out;
  assign port_pin_oe_n = q.oe_n;
  assign mem_addr = q.mem_addr;
  assign mem_rd = q.mem_rd;
  assign mem_wr = q.mem_wr;
  assign mem_wdata = q.mem_wdata;
  assign walk_addr = q.walk;
  assign sa_start = q.sa_start;
  assign sa_stop = q.sa_stop;
  assign sa_clock = q.sa_clock;
  assign sa_probe = q.sa_probe;
  assign disp_mode = q.disp;
  assign disp_value = q.dval;
  assign seg_on = q.seg;
  assign digit_on = q.dig;
  assign ann_on = q.ann;
  assign vco_prog = q.vco;
  assign dac_prog = q.dac;
  assign div2_en = q.div2;
  assign gate_run = q.gate;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic chk_end;
  assign chk_end = q.pwr == PWR_CHECK && q.chk == `CHECK_CYCLES;
  sequence s_window_open;
    sa_start ##1 !sa_start;
  endsequence

  a_dash_check: assert property (q.pwr == PWR_CHECK |-> disp_mode == DISP_DASH) // RULE5
    else $error("display not dashes during power-up check");
  a_ram_fail: assert property (chk_end && !ram_ok |=> disp_mode == DISP_E ##1 s_window_open) // RULE6
    else $error("RAM failure not shown or signalled");
  a_pass_run: assert property (chk_end && ram_ok && prom_ok == 4'hf |=> q.pwr == PWR_RUN) // RULE6
    else $error("passing checks did not enter normal mode");
  a_prom_code: assert property (chk_end && ram_ok && !prom_ok[0] |=> disp_value == 16'h0031 ##1 sa_start) // RULE7
    else $error("wrong program memory error code");
  a_fail_sticky: assert property (q.pwr == PWR_PROM_FAIL |=> q.pwr == PWR_PROM_FAIL) // RULE8
    else $error("failure state left without power cycle");
  a_walk_step: assert property (q.frc[1] && q.ph |=> walk_addr == $past(walk_addr) + 16'h0001 && sa_clock) // RULE3
    else $error("forced instruction walk did not advance");
  a_clock_clean: assert property (sa_clock |=> !sa_clock) // RULE22
    else $error("signature clock strobe longer than one cycle");
  a_port_read: assert property (cpu_rd && pd[5] && !pd[4] |=> cpu_rdata == $past(view[pd[3:0]])) // RULE19
    else $error("port read does not merge latch and pins");
  a_hw_key: assert property (q.pwr == PWR_RUN && $rose(q.hwt[1]) |=> q.test == `T_KEY) // RULE11
    else $error("hardware test input did not start keyboard test");
  a_self_vco: assert property (q.pwr == PWR_RUN && q.test == `T_SELF && !cpu_wr |=> vco_prog == VCO_LO && div2_en) // RULE12
    else $error("self test oscillator setting wrong");
  a_band_gate: assert property (q.test == `T_VCO && !band[1] && !cpu_wr |=> vco_prog == $past(vco_prog)) // RULE17
    else $error("oscillator sweep ran outside bands two and three");
  a_lamp_all: assert property (q.pwr == PWR_RUN && q.test == `T_LAMP && !cpu_wr |=> seg_on == 8'hff && ann_on == 8'hff) // RULE13
    else $error("lamp test left a segment dark");
  a_dac_wrap: assert property (q.pwr == PWR_RUN && q.test == `T_RAMP && q.tick && q.dac == DAC_TOP && !cpu_wr |=> dac_prog == 14'h0000 && sa_start) // RULE16
    else $error("ramp did not wrap at top");
  a_alter_read: assert property (q.pwr == PWR_RUN && q.test == `T_ALTER && key_valid && !key_code[4] && q.ent_n == 3'h3 && !cpu_wr |=> mem_rd && mem_addr == {$past(q.ent_addr[11:0]), $past(key_code[3:0])}) // RULE18
    else $error("fourth digit did not read the address");
endmodule // counter_diagnostic_test_unit

// ---- verification/sig_analyzer.sv ----
// signature analyzer model watching the counter's test strobes
module sig_analyzer (
  input wire logic clk,
  input wire logic start,
  input wire logic stop,
  input wire logic clock,
  input wire logic probe,
  output logic [15:0] sig,
  output int n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic open_q;
  initial begin
    sig = 16'h0000;
    n = 0;
    open_q = 1'b0;
  end
  // samples taken on the strobe edge itself, so a late probe is missed
  always @(posedge clk) begin
    if (start) begin
      open_q <= 1'b1;
      sig <= 16'h0000;
      n <= 0;
    end else if (open_q && clock) begin
      sig <= {sig[14:0], probe ^ sig[15] ^ sig[11] ^ sig[8] ^ sig[6]};
      n <= n + 1;
    end
    if (stop) begin
      open_q <= 1'b0;
    end
  end
endmodule  // sig_analyzer

// ---- verification/tb_counter_diagnostic_test_unit.sv ----
// self-checking bench of the counter diagnostic and test unit
module tb_counter_diagnostic_test_unit;
  import diag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, cpu_wr, cpu_rd, fci, hwk, kv, ram_ok, mem_rd, mem_wr;
  logic sa_start, sa_stop, sa_clock, sa_probe, div2_en, gate_run;
  logic [15:0] cpu_addr, mem_addr, walk_addr, disp_value, sig, w;
  logic [7:0] cpu_wdata, cpu_rdata, sw, rate, mem_rdata, mem_wdata;
  logic [7:0] seg_on, digit_on, ann_on;
  logic [11:0][7:0] pin_in, pin_out, oe_n;
  logic [3:0] prom_ok;
  logic [4:0] kc;
  logic [1:0] band;
  logic [13:0] vco_prog, dac_prog;
  disp_t disp_mode;
  int err_total, check_count, n;
  logic [15:0] base [12] = '{16'hac00, 16'hac02, 16'h9900, 16'h9902,
    16'h9840, 16'h9842, 16'h9820, 16'h9822, 16'h9880, 16'h9882,
    16'h9808, 16'h980a};
  logic [7:0] code [4] = '{8'h31, 8'h32, 8'h33, 8'h36};
  // pin wire: latch where driven, outside level elsewhere
  assign pin_in = (pin_out & ~oe_n) | ({12{8'h3c}} & oe_n);
  // memory lines float to a foreign pattern when not read
  assign mem_rdata = mem_rd ? 8'h77 : 8'h88;
  counter_diagnostic_test_unit dut_u (.clk(clk), .sys_rst(sys_rst),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .port_pin_in(pin_in),
    .port_pin_out(pin_out), .port_pin_oe_n(oe_n), .addr_switch_in(sw),
    .forced_clear_instruction(fci), .hw_key_test(hwk), .ram_ok(ram_ok),
    .prom_ok(prom_ok), .key_valid(kv), .key_code(kc), .sample_rate(rate),
    .band(band), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .walk_addr(walk_addr), .sa_start(sa_start), .sa_stop(sa_stop),
    .sa_clock(sa_clock), .sa_probe(sa_probe), .disp_mode(disp_mode),
    .disp_value(disp_value), .seg_on(seg_on), .digit_on(digit_on),
    .ann_on(ann_on), .vco_prog(vco_prog), .dac_prog(dac_prog),
    .div2_en(div2_en), .gate_run(gate_run));
  sig_analyzer sa_u (.clk(clk), .start(sa_start), .stop(sa_stop),
    .clock(sa_clock), .probe(sa_probe), .sig(sig), .n(n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    chk(cpu_rdata, e);
  endtask
  task automatic key(input logic [4:0] c);
    @(negedge clk);
    kc = c;
    kv = 1'b1;
    @(negedge clk);
    kv = 1'b0;
  endtask
  task automatic rst;
    sys_rst = 1'b1;
    repeat (20) @(negedge clk);
    sys_rst = 1'b0;
  endtask
  // bounded wait for a memory strobe of test 10
  task automatic wait_mem(input bit wq);
    int i;
    for (i = 0; i < 8 && !(wq ? mem_wr : mem_rd); i++) @(negedge clk);
    if (i == 8) begin
      err_total++;
      $display("unexpected at %0t: no memory strobe", $time);
      test_done();
    end
  endtask
  initial begin
    {sys_rst, cpu_wr, cpu_rd, fci, hwk, kv} = 6'h20;
    {cpu_addr, cpu_wdata, kc, band} = '0;
    {ram_ok, prom_ok, sw, rate} = {1'b1, 4'hf, 8'h5e, 8'h00};
    err_total = 0;
    check_count = 0;
    rst();
    chk(disp_mode, DISP_DASH);
    chk(oe_n[0], 8'hff);
    repeat (300) @(negedge clk);
    rd(16'h9c12, 8'h01);
    chk(disp_mode, DISP_NORMAL);
    for (int i = 0; i < 12; i++) begin
      wr(base[i] + 16'h1, 8'h0f);
      wr(base[i], 8'ha5);
      repeat (3) @(negedge clk);
      rd(base[i], 8'h35);
    end
    wr(16'h9843, 8'hff);
    wr(16'h9842, 8'h23);
    repeat (3) @(negedge clk);
    rd(16'h9842, 8'h23);
    wr(16'h9823, 8'hff);
    wr(16'h9821, 8'hff);
    wr(16'h9822, 8'h20);
    wr(16'h9820, 8'h8f);
    repeat (3) @(negedge clk);
    rd(16'h9822, 8'h20);
    rd(16'h9820, 8'h8f);
    rd(16'h9c04, 8'h5e);
    rd(16'h9c3f, 8'h00);
    wr(16'h9c11, 8'h02);
    repeat (3) @(negedge clk);
    chk({seg_on, digit_on}, 16'hffff);
    chk(ann_on, 8'hff);
    wr(16'h9c11, 8'h01);
    repeat (3) @(negedge clk);
    chk({div2_en, gate_run, vco_prog}, {2'b11, 14'd8000});
    wr(16'h9c11, 8'h03);
    repeat (3) @(negedge clk);
    chk($countones(seg_on), 16'd1);
    wr(16'h9c11, 8'h04);
    repeat (3) @(negedge clk);
    chk($countones(digit_on), 16'd1);
    wr(16'h9c11, 8'h06);
    repeat (600) @(negedge clk);
    chk(dac_prog inside {[1:3]}, 16'd1);
    band = 2'd2;
    wr(16'h9c11, 8'h07);
    repeat (600) @(negedge clk);
    chk(vco_prog inside {[8001:8003]}, 16'd1);
    // band one must freeze the sweep where it stands
    band = 2'd1;
    repeat (2) @(negedge clk);
    w = {2'b00, vco_prog};
    repeat (600) @(negedge clk);
    chk({2'b00, vco_prog}, w);
    wr(16'h9c11, 8'h10);
    foreach (w[i]) w[i] = 1'b0;
    key(5'h0);
    key(5'h7);
    key(5'ha);
    key(5'hf);
    wait_mem(1'b0);
    chk(mem_addr, 16'h07af);
    repeat (2) @(negedge clk);
    chk(disp_value[7:0], 8'h77);
    key(5'he);
    key(5'hd);
    wait_mem(1'b1);
    chk({mem_addr, mem_wdata}, {16'h07af, 8'hed});
    key(5'h10);
    wr(16'h9c10, 8'h01);
    wr(16'h9c10, 8'h04);
    wr(16'h9c10, 8'h0c);
    wr(16'h9c10, 8'h00);
    wr(16'h9c10, 8'h08);
    wr(16'h9c10, 8'h02);
    repeat (2) @(negedge clk);
    chk(n, 16'd2);
    hwk = 1'b1;
    repeat (3) @(negedge clk);
    hwk = 1'b0;
    repeat (5) @(negedge clk);
    key(5'h7);
    repeat (3) @(negedge clk);
    chk(disp_value[7:0], 8'h41);
    key(5'h0);
    repeat (3) @(negedge clk);
    chk(disp_value[7:0], 8'h12);
    key(5'h10);
    fci = 1'b1;
    repeat (6) @(negedge clk);
    for (int i = 0; i < 8 && !sa_clock; i++) @(negedge clk);
    chk({15'h0000, sa_clock}, 16'd1);
    w = walk_addr;
    repeat (20) @(negedge clk);
    chk(walk_addr - w, 16'd10);
    fci = 1'b0;
    ram_ok = 1'b0;
    rst();
    repeat (300) @(negedge clk);
    rd(16'h9c12, 8'h02);
    chk(disp_mode, DISP_E);
    chk(n, 16'd16);
    ram_ok = 1'b1;
    // each failing device alone, one power cycle apiece
    for (int i = 0; i < 4; i++) begin
      prom_ok = ~(4'h1 << i);
      rst();
      repeat (300) @(negedge clk);
      chk({disp_mode, disp_value[7:0]}, {DISP_NUM, code[i]});
      chk(n, 16'd16);
      rd(16'h9c12, 8'h03);
    end
    test_done();
  end
endmodule  // tb_counter_diagnostic_test_unit
